// [rtl/pss_defs.svh]
// Constants for the PMIC state and sequencing block
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_CLK_KHZ      40000
`define PSS_RETRY_MS     100
`define PSS_RETRY_CYC    (`PSS_RETRY_MS * `PSS_CLK_KHZ)
`define PSS_RETRY_W      23
`define PSS_DLY_UNIT_US  250
`define PSS_DLY_UNIT_CYC (`PSS_DLY_UNIT_US * `PSS_CLK_KHZ / 1000)
`define PSS_SS_STEP_NS   1000
`define PSS_SS_STEP_CYC  (`PSS_SS_STEP_NS * `PSS_CLK_KHZ / 1000000)
`define PSS_AI_UVLO      0
`define PSS_AI_WIN       1
`define PSS_AI_THERM     2
`define PSS_AI_PEN       3
`define PSS_AI_EXT       4
`define PSS_AI_OV        5
`define PSS_AI_UV        12
`define PSS_TRIG_VIN     4'h7
`define PSS_TRIG_EXT     4'h8
`define PSS_SLP_PRI      2'h0
`define PSS_SLP_ALT      2'h1
`define PSS_LVL_FULL     8'hFF
`endif

// [rtl/pss_pkg.sv]
// Types of the PMIC state and sequencing block
package pss_pkg;
    localparam int NOUT   = 7;
    localparam int NBUCK  = 4;
    localparam int NASYNC = 19;

    typedef enum logic [2:0] {ST_RESET, ST_ACTIVE, ST_SLEEP, ST_THERMAL, ST_FAULT} pss_state_t;
    typedef enum logic [2:0] {SQ_OFF, SQ_WAIT, SQ_DELAY, SQ_RAMP, SQ_ON} pss_seq_t;

    typedef struct packed {
        pss_seq_t    st;
        logic [2:0]  units;
        logic [23:0] cnt;
        logic [7:0]  level;
        logic        en;
        logic        good;
    } pss_seq_reg_t;

    typedef struct packed {
        pss_state_t        st;
        logic [NASYNC-1:0] s1;
        logic [NASYNC-1:0] s2;
        logic [NASYNC-1:0] s3;
        logic [NASYNC-1:0] clean;
        logic              pin_prev;
        logic [22:0]       retry_cnt;
        logic [NOUT-1:0]   go;
        logic [NBUCK-1:0]  alt;
        logic              seq;
        logic [2:0]        rstn;
        logic              regs_restore_n;
        logic              i2c_reset_n;
        logic              i2c_accept;
    } pss_main_reg_t;
endpackage

// [rtl/pss_out_seq.sv]
// Per-output sequencer: trigger gate, turn-on delay, soft-start ramp
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_out_seq
    import pss_pkg::*;
#(
    parameter int DLY_UNIT_CYC = `PSS_DLY_UNIT_CYC,
    parameter int SS_STEP_CYC  = `PSS_SS_STEP_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       go,
    input  wire logic       seq,
    input  wire logic       trig,
    input  wire logic [2:0] delay_sel,
    input  wire logic [1:0] ss_sel,
    output logic            en,
    output logic [7:0]      level,
    output logic            good
);
    pss_seq_reg_t q;
    pss_seq_reg_t d;
    logic [23:0]  step_lim;

    // Ramp step length scales with the soft-start selection
    assign step_lim = 24'(SS_STEP_CYC) * {22'h0, ss_sel} + 24'(SS_STEP_CYC);

    // Dropping go turns the output off at once, whatever the phase
    always_comb begin
        d = q;
        if (!go) begin
            d.st    = SQ_OFF;
            d.en    = 1'b0;
            d.level = 8'h00;
            d.good  = 1'b0;
            d.cnt   = 24'h0;
        end else begin
            case (q.st)
                SQ_OFF: begin
                    if (seq) begin
                        d.st = SQ_WAIT;
                    end else begin
                        d.st = SQ_RAMP;
                        d.en = 1'b1;
                    end
                end
                SQ_WAIT: begin
                    if (trig) begin
                        d.st    = SQ_DELAY;
                        d.units = delay_sel;
                        d.cnt   = 24'h0;
                    end
                end
                SQ_DELAY: begin
                    if (q.units == 3'h0) begin
                        d.st  = SQ_RAMP;
                        d.en  = 1'b1;
                        d.cnt = 24'h0;
                    end else if (q.cnt == 24'(DLY_UNIT_CYC - 1)) begin
                        d.cnt   = 24'h0;
                        d.units = q.units - 3'h1;
                    end else begin
                        d.cnt = q.cnt + 24'h1;
                    end
                end
                SQ_RAMP: begin
                    // Compare with >= so a mid-ramp setting change cannot overshoot
                    if (q.cnt + 24'h1 >= step_lim) begin
                        d.cnt = 24'h0;
                        if (q.level == `PSS_LVL_FULL) begin
                            d.st   = SQ_ON;
                            d.good = 1'b1;
                        end else begin
                            d.level = q.level + 8'h01;
                        end
                    end else begin
                        d.cnt = q.cnt + 24'h1;
                    end
                end
                SQ_ON: d.st = SQ_ON;
                default: d.st = SQ_OFF;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign en    = q.en;
    assign level = q.level;
    assign good  = q.good;

    property p_trig_gate;
        @(posedge clk) disable iff (!rst_b)
        q.st == SQ_WAIT && !trig |=> q.st != SQ_RAMP && !q.en;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("output started before trigger");

    property p_delay_hold;
        @(posedge clk) disable iff (!rst_b)
        q.st == SQ_DELAY && q.units != 3'h0 && go |=> q.st == SQ_DELAY && !q.en;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("turn-on delay cut short");

    property p_ramp_end;
        @(posedge clk) disable iff (!rst_b)
        $rose(q.good) |-> $past(q.level) == `PSS_LVL_FULL && $past(q.st) == SQ_RAMP;
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("good before ramp end");
endmodule // pss_out_seq

// [rtl/pss_ctrl.sv]
// PMIC master state machine with per-output power sequencing
//
// Behaviour
// - Cold reset: regulators off, resets low
// - Cold reset restores all register defaults
// - Cold reset to active on valid input
// - Input lockout returns any state to reset
// - Active from reset uses power-up sequence
// - Sleep transitions unsequenced, soft-start kept
// - Sleep per-output: primary or off; bucks also alternate
// - Sleep entered by configurable hardware pin
// - Bus ignored in sleep; pin exits
// - Overtemperature: thermal state, all off, resets
// - Thermal allow bit blocks thermal entry
// - Output OV or post-ramp UV faults
// - Fault retries to active after 100ms
// - Fault allow bits block fault entry
// - Overcurrent alone never causes fault
// - Output waits for its fixed trigger
// - Output waits its programmable turn-on delay
// - Output ramps over its soft-start time
// - Bucks primary in active, alternate in sleep if programmed
// - Bus receiver held in reset, thermal, fault
// - Pin level toggles sleep when mode zero
`timescale 1ns/1ps
`include "pss_defs.svh"
module pss_ctrl
    import pss_pkg::*;
#(
    parameter int RETRY_CYC    = `PSS_RETRY_CYC,
    parameter int DLY_UNIT_CYC = `PSS_DLY_UNIT_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              vin_uvlo_in,
    input  wire logic              vin_window_in,
    input  wire logic              thermal_over_in,
    input  wire logic              power_enable_pin,
    input  wire logic              external_good_in,
    input  wire logic [NOUT-1:0]   out_ov_in,
    input  wire logic [NOUT-1:0]   out_uv_in,
    input  wire logic              sleep_pin_sel,
    input  wire logic              power_enable_pin_mode,
    input  wire logic              powerdown_via_bus_select,
    input  wire logic              powerdown_allow,
    input  wire logic              sleep_request,
    input  wire logic              thermal_trip_allow,
    input  wire logic              overvolt_fault_allow,
    input  wire logic              undervolt_fault_allow,
    input  wire logic [4*NOUT-1:0] trigger_sel,
    input  wire logic [3*NOUT-1:0] turn_on_delay_sel,
    input  wire logic [2*NOUT-1:0] soft_start_sel,
    input  wire logic [2*NOUT-1:0] sleep_mode_sel,
    output logic [NOUT-1:0]        reg_en,
    output logic [8*NOUT-1:0]      ramp_level,
    output logic [NOUT-1:0]        power_good_signal,
    output logic [NBUCK-1:0]       buck_use_alternate,
    output logic                   main_reset_out_n,
    output logic                   aux_reset_one_out_n,
    output logic                   aux_reset_two_out_n,
    output logic                   regs_restore_n_out,
    output logic                   i2c_reset_n_out,
    output logic                   i2c_accept_out,
    output logic                   thermal_trip_flag,
    output pss_state_t             state_out
);
    pss_main_reg_t    q;
    pss_main_reg_t    d;
    logic [NASYNC-1:0] async_in;
    logic [NOUT-1:0]  trig_w;
    logic [NOUT-1:0]  go_w;
    logic [NBUCK-1:0] alt_w;
    logic             uvlo;
    logic             vin_ok;
    logic             therm_hit;
    logic             fault_hit;
    logic             slp_pin;
    logic             pin_sleep_req;
    logic             bus_sleep_req;
    logic             wake_req;
    logic [22:0]      retry_last;

    assign async_in = {out_uv_in, out_ov_in, external_good_in, power_enable_pin,
                       thermal_over_in, vin_window_in, vin_uvlo_in};
    assign uvlo     = q.clean[`PSS_AI_UVLO];
    assign vin_ok   = q.clean[`PSS_AI_WIN] & ~uvlo;
    assign retry_last = 23'(RETRY_CYC - 1);

    // Masked thermal still reports through the real-time flag
    assign therm_hit = q.clean[`PSS_AI_THERM] & thermal_trip_allow;
    // Only OV and post-ramp UV count; no overcurrent term here
    assign fault_hit =
        (|(q.clean[`PSS_AI_OV +: NOUT] & {NOUT{overvolt_fault_allow}})) |
        (|(q.clean[`PSS_AI_UV +: NOUT] & power_good_signal
           & {NOUT{undervolt_fault_allow}}));

    // Sleep pin is selectable between the enable pin and the external input
    assign slp_pin       = sleep_pin_sel ? q.clean[`PSS_AI_EXT] : q.clean[`PSS_AI_PEN];
    assign pin_sleep_req = !power_enable_pin_mode && !slp_pin;
    assign bus_sleep_req = power_enable_pin_mode && powerdown_via_bus_select
                           && powerdown_allow && sleep_request;
    // Level mode wakes on a high pin, bus mode on any pin edge
    assign wake_req = power_enable_pin_mode ? (slp_pin ^ q.pin_prev) : slp_pin;

    // One sequencer per output; trigger routing is factory fixed
    for (genvar i = 0; i < NOUT; i++) begin : g_out
        logic [3:0] tsel;
        logic [1:0] smode;
        assign tsel  = trigger_sel[4*i +: 4];
        assign smode = sleep_mode_sel[2*i +: 2];
        assign trig_w[i] = (tsel < `PSS_TRIG_VIN) ? power_good_signal[tsel[2:0]] :
                           (tsel == `PSS_TRIG_VIN) ? vin_ok :
                           (tsel == `PSS_TRIG_EXT) ? q.clean[`PSS_AI_EXT] : 1'b1;
        if (i < NBUCK) begin : g_buck
            assign go_w[i]  = (q.st == ST_ACTIVE) ||
                              (q.st == ST_SLEEP && !smode[1]);
            assign alt_w[i] = (q.st == ST_SLEEP) && (smode == `PSS_SLP_ALT);
        end else begin : g_ldo
            assign go_w[i] = (q.st == ST_ACTIVE) ||
                             (q.st == ST_SLEEP && smode == `PSS_SLP_PRI);
        end
        pss_out_seq #(
            .DLY_UNIT_CYC (DLY_UNIT_CYC),
            .SS_STEP_CYC  (`PSS_SS_STEP_CYC)
        ) u_seq (
            .clk       (clk),
            .rst_b     (rst_b),
            .go        (q.go[i]),
            .seq       (q.seq),
            .trig      (trig_w[i]),
            .delay_sel (turn_on_delay_sel[3*i +: 3]),
            .ss_sel    (soft_start_sel[2*i +: 2]),
            .en        (reg_en[i]),
            .level     (ramp_level[8*i +: 8]),
            .good      (power_good_signal[i])
        );
    end

    // Next state; branch order sets the transition priority
    always_comb begin
        d       = q;
        d.s1    = async_in;
        d.s2    = q.s1;
        d.s3    = q.s2;
        // A change is taken only once the last two stages agree
        d.clean = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.clean);
        d.pin_prev = slp_pin;
        d.go    = go_w;
        d.alt   = alt_w;
        case (q.st)
            ST_RESET: begin
                if (vin_ok) begin
                    d.st  = ST_ACTIVE;
                    d.seq = 1'b1;
                end
            end
            ST_ACTIVE: begin
                if (uvlo) begin
                    d.st = ST_RESET;
                end else if (therm_hit) begin
                    d.st = ST_THERMAL;
                end else if (fault_hit) begin
                    d.st        = ST_FAULT;
                    d.retry_cnt = 23'h0;
                end else if (pin_sleep_req || bus_sleep_req) begin
                    d.st  = ST_SLEEP;
                    d.seq = 1'b0;
                end
            end
            ST_SLEEP: begin
                if (uvlo) begin
                    d.st = ST_RESET;
                end else if (therm_hit) begin
                    d.st = ST_THERMAL;
                end else if (fault_hit) begin
                    d.st        = ST_FAULT;
                    d.retry_cnt = 23'h0;
                end else if (wake_req) begin
                    d.st  = ST_ACTIVE;
                    d.seq = 1'b0;
                end
            end
            ST_THERMAL: begin
                if (uvlo) begin
                    d.st = ST_RESET;
                end else if (!therm_hit) begin
                    d.st  = ST_ACTIVE;
                    d.seq = 1'b1;
                end
            end
            ST_FAULT: begin
                if (uvlo) begin
                    d.st = ST_RESET;
                end else if (therm_hit) begin
                    d.st = ST_THERMAL;
                end else if (q.retry_cnt == retry_last) begin
                    d.st  = ST_ACTIVE;
                    d.seq = 1'b1;
                end else begin
                    d.retry_cnt = q.retry_cnt + 23'h1;
                end
            end
            default: d.st = ST_RESET;
        endcase

        // Resets drop in every off state and release once all rails are good
        case (d.st)
            ST_ACTIVE: d.rstn = q.rstn | {3{&power_good_signal}};
            ST_SLEEP:  d.rstn = q.rstn;
            default:   d.rstn = 3'h0;
        endcase
        d.regs_restore_n = (d.st != ST_RESET);
        // Receiver held off while rails may be out of spec
        d.i2c_reset_n = (d.st == ST_ACTIVE) || (d.st == ST_SLEEP);
        d.i2c_accept  = (d.st == ST_ACTIVE);
    end

    // All zero is the cold state: resets low, restore and bus hold asserted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign buck_use_alternate  = q.alt;
    assign main_reset_out_n    = q.rstn[0];
    assign aux_reset_one_out_n = q.rstn[1];
    assign aux_reset_two_out_n = q.rstn[2];
    assign regs_restore_n_out  = q.regs_restore_n;
    assign i2c_reset_n_out     = q.i2c_reset_n;
    assign i2c_accept_out      = q.i2c_accept;
    assign thermal_trip_flag   = q.clean[`PSS_AI_THERM];
    assign state_out           = q.st;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_cold_held;
        (q.st == ST_RESET) [*3];
    endsequence
    sequence s_retry_done;
        q.st == ST_FAULT && q.retry_cnt == retry_last && !uvlo && !therm_hit;
    endsequence

    property p_cold_off;
        s_cold_held |-> reg_en == '0 && q.rstn == 3'h0;
    endproperty
    a_cold_off: assert property (p_cold_off) else $error("rail or reset live in cold");

    property p_cold_regs;
        q.st == ST_RESET |-> !regs_restore_n_out;
    endproperty
    a_cold_regs: assert property (p_cold_regs) else $error("defaults not restored");

    property p_wake;
        q.st == ST_RESET && vin_ok |=> q.st == ST_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("no start on valid input");

    property p_uvlo;
        q.st != ST_RESET && uvlo |=> q.st == ST_RESET;
    endproperty
    a_uvlo: assert property (p_uvlo) else $error("lockout ignored");

    property p_seq_entry;
        q.st == ST_RESET ##1 q.st == ST_ACTIVE |-> q.seq;
    endproperty
    a_seq_entry: assert property (p_seq_entry) else $error("cold start unsequenced");

    property p_sleep_exit;
        q.st == ST_SLEEP ##1 q.st == ST_ACTIVE |-> !q.seq;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit sequenced");

    property p_sleep_ldo;
        q.st == ST_SLEEP ##1 q.st == ST_SLEEP |->
            q.go[NOUT-1] == ($past(sleep_mode_sel[2*NOUT-1 -: 2]) == `PSS_SLP_PRI);
    endproperty
    a_sleep_ldo: assert property (p_sleep_ldo) else $error("linear sleep mode wrong");

    property p_pin_sleep;
        q.st == ST_ACTIVE && pin_sleep_req && !uvlo && !therm_hit && !fault_hit
            |=> q.st == ST_SLEEP;
    endproperty
    a_pin_sleep: assert property (p_pin_sleep) else $error("pin sleep missed");

    property p_sleep_bus;
        q.st == ST_SLEEP |-> !i2c_accept_out;
    endproperty
    a_sleep_bus: assert property (p_sleep_bus) else $error("bus live in sleep");

    property p_therm;
        q.st != ST_RESET && q.st != ST_THERMAL && therm_hit && !uvlo
            |=> q.st == ST_THERMAL && q.rstn == 3'h0;
    endproperty
    a_therm: assert property (p_therm) else $error("thermal entry missed");

    property p_therm_mask;
        q.st == ST_ACTIVE && !thermal_trip_allow |=> q.st != ST_THERMAL;
    endproperty
    a_therm_mask: assert property (p_therm_mask) else $error("masked thermal tripped");

    property p_fault;
        q.st == ST_ACTIVE && fault_hit && !uvlo && !therm_hit
            |=> q.st == ST_FAULT && q.rstn == 3'h0 ##2 reg_en == '0;
    endproperty
    a_fault: assert property (p_fault) else $error("fault entry missed");

    property p_retry;
        s_retry_done |=> q.st == ST_ACTIVE && q.seq;
    endproperty
    a_retry: assert property (p_retry) else $error("retry not taken");

    property p_retry_hold;
        q.st == ST_FAULT && q.retry_cnt != retry_last && !uvlo && !therm_hit
            |=> q.st == ST_FAULT;
    endproperty
    a_retry_hold: assert property (p_retry_hold) else $error("fault left early");

    property p_mask;
        !overvolt_fault_allow && !undervolt_fault_allow && q.st == ST_ACTIVE && !uvlo
            && !therm_hit |=> q.st != ST_FAULT;
    endproperty
    a_mask: assert property (p_mask) else $error("masked fault tripped");

    property p_i2c_hold;
        q.st == ST_RESET || q.st == ST_THERMAL || q.st == ST_FAULT |-> !i2c_reset_n_out;
    endproperty
    a_i2c_hold: assert property (p_i2c_hold) else $error("bus not held");

    property p_therm_exit;
        q.st == ST_THERMAL && !therm_hit && !uvlo |=> q.st == ST_ACTIVE && q.seq;
    endproperty
    a_therm_exit: assert property (p_therm_exit) else $error("thermal exit wrong");
endmodule // pss_ctrl

// [verif/pss_host_model.sv]
// Host model: power-enable pin and bus sleep controls
`timescale 1ns/1ps
module pss_host_model (
    input  wire logic clk,
    output logic      power_enable_pin,
    output logic      power_enable_pin_mode,
    output logic      powerdown_via_bus_select,
    output logic      powerdown_allow,
    output logic      sleep_request
);
    // Pin high and bus sleep disabled from time zero
    initial begin
        {power_enable_pin, power_enable_pin_mode} = 2'h2;
        {powerdown_via_bus_select, powerdown_allow, sleep_request} = 3'h0;
    end
    // Pin is the only way out of sleep
    task automatic pin(input logic v);
        @(negedge clk) power_enable_pin = v;
    endtask
    // Select and allow set before the request; one bit per step, others kept
    task automatic bus_sleep();
        @(negedge clk) power_enable_pin_mode = 1'h1;
        @(negedge clk) powerdown_via_bus_select = 1'h1;
        @(negedge clk) powerdown_allow = 1'h1;
        @(negedge clk) sleep_request = 1'h1;
        @(negedge clk) sleep_request = 1'h0;
    endtask
endmodule // pss_host_model

// [verif/pmic_state_and_sequencing_test.sv]
// Self-checking bench for the state and sequencing controller
`timescale 1ns/1ps
module pmic_state_and_sequencing_test;
    import pss_pkg::*;
    logic       clk = 1'h0, rst_b = 1'h0, uvlo = 1'h0, win = 1'h0, hot = 1'h0, ext = 1'h0;
    logic       t_ok = 1'h0, ov_ok = 1'h0, uv_ok = 1'h1, pin_sel = 1'h0;
    logic [6:0] ov = 7'h00, uv = 7'h00;
    logic [55:0] lvl;
    logic       pen, pmode, psel, pallow, sreq, restore_n, i2c_rst_n, i2c_acc, tflag;
    logic [6:0] en, good;
    logic [3:0] alt;
    logic [2:0] rstn;
    pss_state_t st;
    int         miscompares = 0;
    int         samples_checked = 0;

    always #12.5 clk = ~clk;

    pss_host_model i_host (.clk(clk), .power_enable_pin(pen), .power_enable_pin_mode(pmode),
        .powerdown_via_bus_select(psel), .powerdown_allow(pallow), .sleep_request(sreq));

    // Short retry and delay unit keep the run brief
    pss_ctrl #(.RETRY_CYC(50), .DLY_UNIT_CYC(8)) i_dut (.clk(clk), .rst_b(rst_b),
        .vin_uvlo_in(uvlo), .vin_window_in(win), .thermal_over_in(hot),
        .power_enable_pin(pen), .external_good_in(ext), .out_ov_in(ov), .out_uv_in(uv),
        .sleep_pin_sel(pin_sel), .power_enable_pin_mode(pmode), .powerdown_via_bus_select(psel),
        .powerdown_allow(pallow), .sleep_request(sreq), .thermal_trip_allow(t_ok),
        .overvolt_fault_allow(ov_ok), .undervolt_fault_allow(uv_ok),
        .trigger_sel(28'hFFF8F0F), .turn_on_delay_sel(21'h000008),
        .soft_start_sel(14'h0000), .sleep_mode_sel(14'h0229), .reg_en(en), .ramp_level(lvl),
        .power_good_signal(good), .buck_use_alternate(alt), .main_reset_out_n(rstn[2]),
        .aux_reset_one_out_n(rstn[1]), .aux_reset_two_out_n(rstn[0]),
        .regs_restore_n_out(restore_n), .i2c_reset_n_out(i2c_rst_n),
        .i2c_accept_out(i2c_acc), .thermal_trip_flag(tflag), .state_out(st));

    task automatic fail(input string m);
        miscompares++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk_st(input pss_state_t e);
        samples_checked++;
        if (st !== e) fail($sformatf("state %0d want %0d", st, e));
    endtask
    task automatic chk_v(input logic [7:0] g, input logic [7:0] e, input string m);
        samples_checked++;
        if (g !== e) fail($sformatf("%s got %h want %h", m, g, e));
    endtask
    // Bounded wait, sampled at the falling edge
    task automatic wait_st(input pss_state_t e, input int n);
        for (int i = 0; i < n && st !== e; i++) @(negedge clk);
        chk_st(e);
    endtask
    task automatic wait_bit(input int b, input int n);
        for (int i = 0; i < n && good[b] !== 1'h1; i++) @(negedge clk);
    endtask

    task automatic t_reset();
        chk_st(ST_RESET);
        chk_v({1'h0, en}, 8'h00, "reg_en");
        chk_v({5'h00, rstn}, 8'h00, "resets");
        chk_v({6'h00, restore_n, i2c_rst_n}, 8'h00, "restore");
        $display("reset test done");
    endtask
    task automatic t_power_up();
        win = 1'h1;
        wait_st(ST_ACTIVE, 10);
        chk_v({7'h00, restore_n}, 8'h01, "restore");
        repeat (100) @(negedge clk);
        chk_v({7'h00, en[3]}, 8'h00, "ext gate");
        ext = 1'h1;
        repeat (10000) @(negedge clk);
        chk_v({7'h00, good[0]}, 8'h00, "ramp short");
        wait_bit(0, 1000);
        chk_v({7'h00, en[1]}, 8'h00, "trig gate");
        repeat (4) @(negedge clk);
        chk_v({7'h00, en[1]}, 8'h00, "delay");
        repeat (12) @(negedge clk);
        chk_v({7'h00, en[1]}, 8'h01, "delay end");
        for (int i = 0; i < 12000 && good !== 7'h7F; i++) @(negedge clk);
        chk_v({1'h0, good}, 8'h7F, "good");
        chk_v(lvl[7:0], 8'hFF, "full level");
        repeat (3) @(negedge clk);
        chk_v({5'h00, rstn}, 8'h07, "resets");
        $display("power-up test done");
    endtask
    task automatic t_sleep();
        i_host.pin(1'h0);
        wait_st(ST_SLEEP, 10);
        repeat (3) @(negedge clk);
        chk_v({1'h0, en}, 8'h69, "sleep en");
        chk_v({4'h0, alt}, 8'h01, "alt");
        chk_v({7'h00, i2c_acc}, 8'h00, "accept");
        i_host.pin(1'h1);
        wait_st(ST_ACTIVE, 10);
        repeat (3) @(negedge clk);
        chk_v({1'h0, en}, 8'h7F, "wake en");
        chk_v({7'h00, good[1]}, 8'h00, "wake ramp");
        chk_v(lvl[15:8], 8'h00, "ramp base");
        chk_v({4'h0, alt}, 8'h00, "primary");
        // Sleep pin moved to the external input
        pin_sel = 1'h1;
        ext = 1'h0;
        wait_st(ST_SLEEP, 10);
        ext = 1'h1;
        wait_st(ST_ACTIVE, 10);
        pin_sel = 1'h0;
        i_host.bus_sleep();
        wait_st(ST_SLEEP, 10);
        i_host.pin(1'h0);
        wait_st(ST_ACTIVE, 10);
        $display("sleep test done");
    endtask
    task automatic t_faults();
        hot = 1'h1;
        ov = 7'h04;
        repeat (10) @(negedge clk);
        chk_st(ST_ACTIVE);
        chk_v({7'h00, tflag}, 8'h01, "flag");
        {t_ok, ov_ok} = 2'h3;
        wait_st(ST_THERMAL, 3);
        repeat (2) @(negedge clk);
        chk_v({en, i2c_rst_n}, 8'h00, "thermal");
        hot = 1'h0;
        wait_st(ST_ACTIVE, 10);
        wait_st(ST_FAULT, 10);
        repeat (2) @(negedge clk);
        chk_v({en, rstn[0]}, 8'h00, "fault");
        repeat (40) @(negedge clk);
        chk_st(ST_FAULT);
        wait_st(ST_ACTIVE, 20);
        wait_st(ST_FAULT, 10);
        ov = 7'h00;
        wait_st(ST_ACTIVE, 80);
        // Undervolt counts only once the ramp is done and allowed
        uv = 7'h01;
        repeat (10) @(negedge clk);
        chk_st(ST_ACTIVE);
        {ov_ok, uv_ok} = 2'h0;
        wait_bit(0, 11000);
        chk_v({7'h00, good[0]}, 8'h01, "uv ramp");
        repeat (2) @(negedge clk);
        chk_st(ST_ACTIVE);
        {ov_ok, uv_ok} = 2'h3;
        wait_st(ST_FAULT, 3);
        uv = 7'h00;
        wait_st(ST_ACTIVE, 80);
        uvlo = 1'h1;
        wait_st(ST_RESET, 10);
        $display("fault test done");
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'h1;
        t_reset();
        t_power_up();
        t_sleep();
        t_faults();
        wrap_up();
    end
    // Watchdog well beyond the expected run
    initial begin
        #(60000 * 25);
        fail("watchdog");
        wrap_up();
    end
endmodule // pmic_state_and_sequencing_test
